// [saa_pkg.sv]
// shared constants and types of the serial attenuator control link
// assumes nothing beyond a SystemVerilog compiler
package saa_pkg;

    // word layout on the link
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned LEVEL_W    = 8;
    localparam int unsigned FRAME_BITS = ADDR_W + LEVEL_W;
    localparam int unsigned CNT_W      = 5;
    localparam logic [ADDR_W-1:0]  CHANNEL_ADDR = 8'h00;
    localparam logic [LEVEL_W-1:0] MUTE_CODE    = 8'h3F;

    // switch selection: 63 attenuation steps plus mute
    localparam int unsigned IDX_W = 6;
    localparam int unsigned SEL_W = 64;
    localparam logic [IDX_W-1:0] MUTE_IDX = 6'h3F;

    // timing at the controller clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned LEAD_NS       = 150;
    localparam int unsigned SCLK_HALF_NS  = 250;
    localparam int unsigned TMR_W         = 8;
    localparam logic [TMR_W-1:0] LEAD_CYC =
        TMR_W'((LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] HALF_CYC =
        TMR_W'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // controller register offsets
    localparam int unsigned REG_AW = 2;
    localparam logic [REG_AW-1:0] REG_LEVEL  = 2'h0;
    localparam logic [REG_AW-1:0] REG_ADDR   = 2'h1;
    localparam logic [REG_AW-1:0] REG_STATUS = 2'h2;

    // values after reset
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h3F;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 8'h00;

    // controller states, gray along idle-lead-high-low
    typedef enum logic [1:0] {
        SAA_IDLE = 2'b00,
        SAA_LEAD = 2'b01,
        SAA_HIGH = 2'b11,
        SAA_LOW  = 2'b10
    } saa_state_t;

endpackage

// [saa_link_if.sv]
// three-wire link between the controller and the attenuator
// assumes the controller drives all three wires
`timescale 1ns/1ps
`default_nettype none

interface saa_link_if;
    logic sclk;   // serial clock, idles low
    logic loadN;  // framing line, low during a frame
    logic sdata;  // serial data, msb first

    modport host (output sclk, output loadN, output sdata);
    modport dev  (input sclk, input loadN, input sdata);
endinterface

`default_nettype wire

// [saa_timer.sv]
// down-counter that pulses done a set number of cycles after start
// assumes start and count come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module saa_timer
    import saa_pkg::*;
#(
    parameter int unsigned W = TMR_W
)(
    // clock and control
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // request
    input  wire logic         start,
    input  wire logic [W-1:0] count,
    // answer
    output logic              done
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // next count: load on start, else run down to zero
    always_comb
    begin
        cnt_next = cnt_reg;
        if (!rst_n)
            cnt_next = '0;
        else if (ce && start)
            cnt_next = count;
        else if (ce && cnt_reg != '0)
            cnt_next = cnt_reg - W'(1);
    end

    always_ff @(posedge clock)
    begin
        cnt_reg <= cnt_next;
    end

    // done in the last counted cycle
    assign done = ce && (cnt_reg == W'(1));

endmodule // saa_timer

`default_nettype wire

// [saa_device.sv]
// attenuator end: shifts in the serial word, latches it, decodes it
// assumes the controller keeps its framing and clocking duties
`timescale 1ns/1ps
`default_nettype none

module saa_device
    import saa_pkg::*;
(
    // link, clocked by the serial clock
    saa_link_if.dev             link,
    // control
    input  wire logic           rst_n,
    input  wire logic           ce,
    // applied setting
    output logic [SEL_W-1:0]    switchSel,
    output logic [IDX_W-1:0]    attenDb,
    output logic                muted
);

    ////////////////////////////////////////////////////////////////////
    // shift domain, clocked by the serial clock

    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;

    // shift msb first while framed; older bits fall off the top
    always_comb
    begin
        shift_next = shift_reg;
        if (!rst_n)
            shift_next = '0;
        else if (ce && !link.loadN)
            shift_next = {shift_reg[FRAME_BITS-2:0], link.sdata};
    end

    always_ff @(posedge link.sclk)
    begin
        shift_reg <= shift_next;
    end

    ////////////////////////////////////////////////////////////////////
    // latch domain, clocked by the rising framing line
    // the serial clock is idle whenever the framing line rises, so the
    // shift register stands still across this edge

    logic [ADDR_W-1:0]  wordAddr;
    logic [LEVEL_W-1:0] wordLevel;
    logic [IDX_W-1:0]   wordIdx;
    logic               wordValid;

    // split the word into address and level code
    assign wordAddr  = shift_reg[FRAME_BITS-1:LEVEL_W];
    assign wordLevel = shift_reg[LEVEL_W-1:0];
    assign wordValid = (wordAddr == CHANNEL_ADDR);

    // clamp the level code onto the step index
    always_comb
    begin
        if (wordLevel >= MUTE_CODE)
            wordIdx = MUTE_IDX;
        else
            wordIdx = wordLevel[IDX_W-1:0];
    end

    logic [IDX_W-1:0] idx_reg;
    logic [IDX_W-1:0] idx_next;
    logic [SEL_W-1:0] sel_reg;
    logic [SEL_W-1:0] sel_next;
    logic             mute_reg;
    logic             mute_next;

    // one-hot switch selection from the next index
    genvar g;
    generate
        for (g = 0; g < SEL_W; g++)
        begin : gSel
            assign sel_next[g] = (idx_next == IDX_W'(g));
        end
    endgenerate

    // next applied setting: reset to mute, else take a valid word
    always_comb
    begin
        idx_next = idx_reg;
        if (!rst_n)
            idx_next = MUTE_IDX;
        else if (ce && wordValid)
            idx_next = wordIdx;
        mute_next = (idx_next == MUTE_IDX);
    end

    always_ff @(posedge link.loadN)
    begin
        idx_reg  <= idx_next;
        sel_reg  <= sel_next;
        mute_reg <= mute_next;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, straight from the latch flops

    // setting as applied to the ladder
    assign switchSel = sel_reg;
    assign attenDb   = idx_reg;
    assign muted     = mute_reg;

endmodule // saa_device

`default_nettype wire

// [saa_host.sv]
// controller end: takes a level from software and sends one frame
// assumes software on the same clock, link clock made here by division
//
// What this block does
// - framing line low 150 ns before first clock
// - framing line stays low for all 16 bits
// - address byte then level byte, msb first
// - controller sends the address held in REG_ADDR, all zeros after reset
// - nonzero address leaves setting unchanged
// - framing line rise latches and applies word
// - codes 0 to 62 give that many dB
// - codes 63 and above select mute
// - muted after a framing line rise with device reset low, until first valid word
// - shift data on rising clock while framed
// - clock falls no later than 20 ns after frame
// - exactly one switch selection active once the first word is latched
// - controller should step through every 1 dB code; it sends only the level that software writes
`timescale 1ns/1ps
`default_nettype none

module saa_host
    import saa_pkg::*;
(
    // clock and control
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                ce,
    // register port
    input  wire logic [REG_AW-1:0]   regAddr,
    input  wire logic [LEVEL_W-1:0]  regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [LEVEL_W-1:0]  regRdata,
    // status
    output logic                     busy,
    // link
    saa_link_if.host                 link
);

    ////////////////////////////////////////////////////////////////////
    // state

    saa_state_t             state_reg, state_next;
    logic [FRAME_BITS-1:0]  tx_reg, tx_next;
    logic [CNT_W-1:0]       bits_reg, bits_next;
    logic                   sclk_reg, sclk_next;
    logic                   loadN_reg, loadN_next;
    logic                   sdata_reg, sdata_next;
    logic [LEVEL_W-1:0]     level_reg, level_next;
    logic [ADDR_W-1:0]      addr_reg, addr_next;
    logic [LEVEL_W-1:0]     rdata_reg, rdata_next;
    logic                   tmrStart;
    logic [TMR_W-1:0]       tmrCount;
    logic                   tmrDone;
    logic                   sendReq;

    // lead and half-period timing
    saa_timer #(.W(TMR_W)) uTimer (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .start (tmrStart),
        .count (tmrCount),
        .done  (tmrDone)
    );

    // a level write while idle starts a frame
    assign sendReq = regWr && (regAddr == REG_LEVEL)
                     && (state_reg == SAA_IDLE);
    assign busy    = (state_reg != SAA_IDLE);

    ////////////////////////////////////////////////////////////////////
    // registers seen by software

    always_comb
    begin
        level_next = level_reg;
        addr_next  = addr_reg;
        rdata_next = '0;
        if (!rst_n)
        begin
            level_next = LEVEL_RST;
            addr_next  = ADDR_RST;
        end
        else if (ce)
        begin
            if (sendReq)
                level_next = regWdata;
            if (regWr && regAddr == REG_ADDR && !busy)
                addr_next = regWdata;
            if (regRd)
            begin
                unique case (regAddr)
                    REG_LEVEL:  rdata_next = level_reg;
                    REG_ADDR:   rdata_next = addr_reg;
                    REG_STATUS: rdata_next = {{(LEVEL_W-1){1'b0}}, busy};
                    default:    rdata_next = '0;
                endcase
            end
        end
        else
            rdata_next = rdata_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // frame sequencer

    always_comb
    begin
        state_next = state_reg;
        tx_next    = tx_reg;
        bits_next  = bits_reg;
        sclk_next  = sclk_reg;
        loadN_next = loadN_reg;
        sdata_next = sdata_reg;
        tmrStart   = 1'b0;
        tmrCount   = HALF_CYC;
        if (!rst_n)
        begin
            state_next = SAA_IDLE;
            tx_next    = '0;
            bits_next  = '0;
            sclk_next  = 1'b0;
            loadN_next = 1'b1;
            sdata_next = 1'b0;
        end
        else if (ce)
        begin
            unique case (state_reg)
                SAA_IDLE:
                begin
                    if (sendReq)
                    begin
                        // clock already low when the frame opens
                        tx_next    = {addr_reg, regWdata};
                        sdata_next = addr_reg[ADDR_W-1];
                        loadN_next = 1'b0;
                        bits_next  = '0;
                        tmrStart   = 1'b1;
                        tmrCount   = LEAD_CYC;
                        state_next = SAA_LEAD;
                    end
                end
                SAA_LEAD:
                begin
                    if (tmrDone)
                    begin
                        sclk_next  = 1'b1;
                        tmrStart   = 1'b1;
                        state_next = SAA_HIGH;
                    end
                end
                SAA_HIGH:
                begin
                    if (tmrDone)
                    begin
                        // data changes on the falling edge
                        sclk_next  = 1'b0;
                        tx_next    = {tx_reg[FRAME_BITS-2:0], 1'b0};
                        sdata_next = tx_reg[FRAME_BITS-2];
                        bits_next  = bits_reg + CNT_W'(1);
                        tmrStart   = 1'b1;
                        state_next = SAA_LOW;
                    end
                end
                SAA_LOW:
                begin
                    if (tmrDone)
                    begin
                        if (bits_reg == CNT_W'(FRAME_BITS))
                        begin
                            loadN_next = 1'b1;
                            sdata_next = 1'b0;
                            state_next = SAA_IDLE;
                        end
                        else
                        begin
                            sclk_next  = 1'b1;
                            tmrStart   = 1'b1;
                            state_next = SAA_HIGH;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        state_reg <= state_next;
        tx_reg    <= tx_next;
        bits_reg  <= bits_next;
        sclk_reg  <= sclk_next;
        loadN_reg <= loadN_next;
        sdata_reg <= sdata_next;
        level_reg <= level_next;
        addr_reg  <= addr_next;
        rdata_reg <= rdata_next;
    end

    // pins and read data from flops
    assign link.sclk  = sclk_reg;
    assign link.loadN = loadN_reg;
    assign link.sdata = sdata_reg;
    assign regRdata   = rdata_reg;

endmodule // saa_host

`default_nettype wire

// [saa_pkg_unused_guard.sv]
// intentionally empty compilation unit: no design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [saa_link_props.sv]
// checker for the three-wire link and the applied setting
// assumes host clock domain; device outputs sampled on that clock
`timescale 1ns/1ps
`default_nettype none

module saa_link_props
    import saa_pkg::*;
(
    // host side
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic             busy,
    // link wires
    input wire logic             sclk,
    input wire logic             loadN,
    input wire logic             sdata,
    // device outputs
    input wire logic [SEL_W-1:0] switchSel,
    input wire logic [IDX_W-1:0] attenDb,
    input wire logic             muted
);
    logic        armed_reg;
    logic [4:0]  riseCnt_reg;
    logic [15:0] word_reg;

    // count rises, shadow the word, arm after first latch
    always_ff @(posedge clock)
    begin
        armed_reg <= rst_n && (armed_reg || $rose(loadN));
        if (!rst_n || loadN)
            riseCnt_reg <= 5'd0;
        else if ($rose(sclk))
            riseCnt_reg <= riseCnt_reg + 5'd1;
        if (!loadN && $rose(sclk))
            word_reg <= {word_reg[14:0], sdata};
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////
    property p_lead;
        $fell(loadN) |-> !sclk[*8] ##1 !sclk[*7] ##1 sclk;
    endproperty
    a_lead: assert property (p_lead)
        else $error("lead before first sclk rise wrong");
    property p_bits;
        $rose(loadN) |-> riseCnt_reg == 5'd16;
    endproperty
    a_bits: assert property (p_bits)
        else $error("frame did not carry 16 rises");
    property p_framed;
        !loadN |-> busy;
    endproperty
    a_framed: assert property (p_framed)
        else $error("framing low while host idle");
    property p_idle;
        loadN |-> !sclk;
    endproperty
    a_idle: assert property (p_idle)
        else $error("sclk high outside a frame");
    property p_stable;
        $rose(sclk) |-> $stable(sdata);
    endproperty
    a_stable: assert property (p_stable)
        else $error("sdata moved at sclk rise");
    property p_onehot;
        armed_reg |-> $onehot(switchSel);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("switch select not one-hot");
    property p_index;
        armed_reg |-> switchSel[attenDb] && muted == (attenDb == MUTE_IDX);
    endproperty
    a_index: assert property (p_index)
        else $error("select, index and mute disagree");
    property p_hold;
        armed_reg && $changed(attenDb) |-> $rose(loadN);
    endproperty
    a_hold: assert property (p_hold)
        else $error("setting changed without a latch");
    property p_decode;
        armed_reg && $rose(loadN) && word_reg[15:8] == CHANNEL_ADDR
        |-> attenDb == (word_reg[7:0] > 8'd62 ? MUTE_IDX : word_reg[5:0]);
    endproperty
    a_decode: assert property (p_decode)
        else $error("decoded level wrong");
    property p_ignore;
        armed_reg && $rose(loadN) && word_reg[15:8] != CHANNEL_ADDR
        |-> $stable(attenDb) && $stable(muted);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("foreign address changed setting");

    // main scenarios
    c_mute: cover property (armed_reg && $rose(loadN) && muted);
    c_foreign: cover property (armed_reg && $rose(loadN) && word_reg[8]);
    c_shift: cover property (!loadN && $rose(sclk));
endmodule // saa_link_props

`default_nettype wire

// [tb.sv]
// testbench: host and device joined by the link, plus a bench-fed device
// assumes the package constants and a 100 MHz system clock
`timescale 1ns/1ps
`default_nettype none

module tb
    import saa_pkg::*;
;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic               devRstN = 1'b0;
    logic [REG_AW-1:0]  regAddr = '0;
    logic [LEVEL_W-1:0] regWdata = '0;
    logic               regWr = 1'b0;
    logic               regRd = 1'b0;
    logic [LEVEL_W-1:0] regRdata;
    logic               busy, muted, muted2;
    logic [SEL_W-1:0]   switchSel, switchSel2;
    logic [IDX_W-1:0]   attenDb, attenDb2;
    logic [7:0]         codes [7] = '{8'h00, 8'h01, 8'h3E, 8'h3F,
                                      8'h40, 8'hFF, 8'h1F};
    int                 n_fail = 0;
    int                 cmp_count = 0;

    saa_link_if link();
    saa_link_if link2();

    always #5 clock = ~clock;

    // both ends on the first link, a lone device on the second
    saa_host saa_host_inst (.clock(clock), .rst_n(rst_n), .ce(1'b1),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .busy(busy), .link(link));
    saa_device saa_device_inst (.link(link), .rst_n(devRstN), .ce(1'b1),
        .switchSel(switchSel), .attenDb(attenDb), .muted(muted));
    saa_device saa_device_inst_b (.link(link2), .rst_n(devRstN),
        .ce(1'b1), .switchSel(switchSel2), .attenDb(attenDb2),
        .muted(muted2));
    saa_link_props saa_link_props_inst (.clock(clock), .rst_n(rst_n),
        .busy(busy), .sclk(link.sclk), .loadN(link.loadN),
        .sdata(link.sdata), .switchSel(switchSel), .attenDb(attenDb),
        .muted(muted));

    ////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clock);
        regWr    <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clock);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic rdc(input logic [REG_AW-1:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // poll the status register until the frame is over
    task automatic waitIdle;
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 1000 && s[0] !== 1'b0; i++)
            rd(REG_STATUS, s);
        if (s[0] !== 1'b0)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic setLevel(input logic [7:0] c);
        logic [IDX_W-1:0] e;
        e = (c > 8'd62) ? MUTE_IDX : c[5:0];
        wr(REG_LEVEL, c);
        if (c == 8'h00)
        begin
            wr(REG_LEVEL, 8'h22);
            rdc(REG_STATUS, 8'h01);
        end
        waitIdle();
        chk(attenDb, e);
        chk(muted, c > 8'd62);
        chk(switchSel, 64'd1 << e);
        rdc(REG_LEVEL, c);
    endtask

    // bench-made link clock, 15 ns period, still outside frames
    task automatic send2(input logic [23:0] w, input int n);
        link2.loadN = 1'b0;
        #150;
        for (int i = n - 1; i >= 0; i--)
        begin
            link2.sdata = w[i];
            #7.5 link2.sclk = 1'b1;
            #7.5 link2.sclk = 1'b0;
        end
        #7.5 link2.loadN = 1'b1;
        link2.sdata = ~w[0];
        #7.5; // let the latched setting settle before it is read
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        link2.sclk  = 1'b0;
        link2.loadN = 1'b1;
        link2.sdata = 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rdc(REG_LEVEL, LEVEL_RST);
        rdc(REG_ADDR, ADDR_RST);
        rdc(REG_STATUS, 8'h00);
        rdc(2'h3, 8'h00);
        // latch edges with device reset low give power-up mute
        wr(REG_LEVEL, 8'h05);
        send2(24'h00_0005, 16);
        waitIdle();
        devRstN <= 1'b1;
        chk(muted, 1'b1);
        chk(attenDb, MUTE_IDX);
        chk(attenDb2, MUTE_IDX);
        chk(muted2, 1'b1);
        foreach (codes[i])
            setLevel(codes[i]);
        // foreign channel address leaves the setting alone
        wr(REG_ADDR, 8'h01);
        rdc(REG_ADDR, 8'h01);
        wr(REG_LEVEL, 8'h07);
        waitIdle();
        chk(attenDb, 6'h1F);
        wr(REG_ADDR, 8'h00);
        // one dB at a time up to the last step
        for (int s = 8'h3C; s < 8'h3E; s++)
            setLevel(8'(s));
        setLevel(8'h3E);
        // twenty bits: the last sixteen count
        send2(24'h0A_0009, 20);
        chk(attenDb2, 6'h09);
        chk(switchSel2, 64'h1 << 9);
        send2(24'h00_0030, 16);
        chk(attenDb2, 6'h30);
        chk(muted2, 1'b0);
        // reset again in mid-run
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc(REG_LEVEL, LEVEL_RST);
        rdc(REG_STATUS, 8'h00);
        chk(attenDb, 6'h3E);
        results();
    end
endmodule // tb

`default_nettype wire
